/* File: include/csr_pkg.sv */
// core status register bank: shared constants, field positions, op codes
// assumes: 9-bit file address, 8-bit data, apb word per file location
package csr_pkg;

  // ---------------------------------------------------------------
  // file address map (register index; byte address is index * 4)
  // ---------------------------------------------------------------
  localparam logic [6:0] IDX_INDIRECT_WINDOW   = 7'h00; // no storage
  localparam logic [6:0] IDX_TIMER_OPTION      = 7'h01; // option odd banks
  localparam logic [6:0] IDX_PROGRAM_COUNTER_L = 7'h02;
  localparam logic [6:0] IDX_CORE_STATUS       = 7'h03;
  localparam logic [6:0] IDX_INDIRECT_POINTER  = 7'h04;
  localparam logic [6:0] IDX_PC_HIGH_BUFFER    = 7'h0a;
  localparam logic [6:0] IDX_INTERRUPT_CONTROL = 7'h0b;
  localparam logic [6:0] IDX_RAM_FIRST         = 7'h20; // below: sfr area
  localparam logic [8:0] IDX_OPTION_FULL       = 9'h081;
  localparam logic [8:0] IDX_OPTION_MIRROR     = 9'h181;

  // ---------------------------------------------------------------
  // core status field positions
  // ---------------------------------------------------------------
  localparam int BIT_INDIRECT_BANK   = 7;
  localparam int BIT_DIRECT_BANK_HI  = 6;
  localparam int BIT_DIRECT_BANK_LO  = 5;
  localparam int BIT_WATCHDOG_EXPIRY = 4;
  localparam int BIT_SLEEP_ENTRY     = 3;
  localparam int BIT_ZERO            = 2;
  localparam int BIT_NIBBLE_OVERFLOW = 1;
  localparam int BIT_CARRY           = 0;
  localparam logic [2:0] FLAG_ZERO   = 3'h4; // flag mask within bits 2:0
  localparam logic [2:0] FLAG_CARRY  = 3'h1;
  localparam logic [2:0] FLAG_ALL    = 3'h7;

  // option: prescaler assigned to the watchdog when set
  localparam int BIT_PRESCALER_TO_WATCHDOG = 3;
  localparam int PCH_BUFFER_BITS           = 5; // upper 3 bits read zero

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CORE_STATUS  = 8'h18; // flags forced to 0
  localparam logic [7:0] RST_PC_LOW       = 8'h00;
  localparam logic [7:0] RST_PC_HIGH_BUF  = 8'h00;
  localparam logic [7:0] RST_POINTER      = 8'h00;
  localparam logic [7:0] RST_INTR_CONTROL = 8'h00;
  localparam logic [7:0] RST_OPTION       = 8'hff;

  // ---------------------------------------------------------------
  // core operations presented by the instruction sequencer
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_CLEAR, OP_MOVE,
    OP_BIT_SET, OP_BIT_CLEAR, OP_SWAP, OP_ROT_LEFT, OP_ROT_RIGHT,
    OP_SLEEP, OP_WATCHDOG_KICK
  } csr_op_e;

endpackage

/* File: hw/csr_file_ram.sv */
// general purpose file memory behind the core register bank
// assumes: one write and one registered read per clock, same clock
`timescale 1ns/1ps
module csr_file_ram #(
  parameter int DEPTH  = 512,
  parameter int ADDR_W = 9
) (
  // clock
  input  wire logic              i_mclk,
  // write port
  input  wire logic              i_wr_en,
  input  wire logic [ADDR_W-1:0] i_wr_addr,
  input  wire logic [7:0]        i_wr_data,
  // read port, data one clock later
  input  wire logic              i_rd_en,
  input  wire logic [ADDR_W-1:0] i_rd_addr,
  output logic      [7:0]        o_rd_data
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] mem [DEPTH]; // contents undefined after power-up

  generate
    if (DEPTH > (1 << ADDR_W) || DEPTH < 1) begin : g_bad_depth
      $error("csr_file_ram: depth does not fit the address width");
    end
  endgenerate

  // write and registered read; no reset, like static ram
  always_ff @(posedge i_mclk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule // csr_file_ram

/* File: hw/csr_core_status.sv */
// core status register bank: status flags, bank select, indirect access,
// program counter bytes, interrupt control, option, file memory
// assumes: apb master for software, one core op at a time, same clock
//
// Operation
// - flag-setting op to status keeps flag results
// - reset-cause bits read-only, power up as one
// - clear of status: bank bits zero, zero set
// - bit, swap, move ops leave flags alone
// - subtract adds complement; carry means no borrow
// - indirect bank bit picks bank pair
// - two direct bank bits pick one bank
// - expiry/sleep bits follow power-up, kick, sleep, timeout
// - zero flag tracks zero result
// - nibble flag is carry out of bit three
// - carry flag is carry out of top bit
// - rotates load carry with shifted-out bit
// - status decoded in every bank
// - indirect window reaches memory through pointer
// - unimplemented locations read zero, ignore writes
// - option mirrored; watchdog prescale gives timer 1:1
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module csr_core_status #(
  parameter int RAM_DEPTH = 512
) (
  // clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_n,
  // apb slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [11:0]           i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic                       o_pready,
  output logic      [31:0]           o_prdata,
  output logic                       o_pslverr,
  // core operation request and answer
  input  wire logic                  i_op_valid,
  input  wire csr_pkg::csr_op_e      i_op_code,
  input  wire logic [6:0]            i_op_addr,
  input  wire logic [7:0]            i_op_w,
  input  wire logic [2:0]            i_op_bit,
  input  wire logic                  i_op_to_file,
  output logic                       o_op_ready,
  output logic                       o_op_done,
  output logic      [7:0]            o_op_result,
  // watchdog event
  input  wire logic                  i_wdt_timeout,
  // register contents seen by the rest of the core
  output logic      [7:0]            o_core_status,
  output logic      [7:0]            o_indirect_pointer,
  output logic      [7:0]            o_program_counter_low,
  output logic      [7:0]            o_program_counter_high_buffer,
  output logic      [7:0]            o_interrupt_control,
  output logic      [7:0]            o_prescaler_option,
  output logic                       o_timer_zero_undivided
);

  // ---------------------------------------------------------------
  // checks and types
  // ---------------------------------------------------------------
  generate
    if (RAM_DEPTH != 512) begin : g_bad_depth
      $error("csr_core_status: four banks need 512 file locations");
    end
  endgenerate

  typedef enum logic [1:0] {
    ST_IDLE, ST_OP_EXEC, ST_BUS_READ, ST_BUS_ACK
  } csr_st_e;

  typedef struct packed {
    csr_st_e          st;          // sequencer state
    logic [7:0]       status;      // core status
    logic [7:0]       pointer;     // indirect pointer
    logic [7:0]       pc_low;      // program counter low byte
    logic [7:0]       pc_high_buf; // upper pc write buffer
    logic [7:0]       intr_ctrl;   // interrupt control
    logic [7:0]       option;      // prescaler option
    csr_pkg::csr_op_e op_code;     // latched op
    logic [7:0]       op_w;        // latched working value
    logic [2:0]       op_bit;      // latched bit index
    logic             op_to_file;  // result goes back to the file
    logic [8:0]       eff_addr;    // resolved file address
    logic             op_done;     // answer strobe
    logic [7:0]       op_result;   // answer data
    logic [31:0]      prdata;      // bus read data
  } csr_state_s;

  csr_state_s r;      // registered state
  csr_state_s next_r; // next state

  // ram hookup
  logic       ram_wr_en;
  logic [8:0] ram_wr_addr;
  logic [7:0] ram_wr_data;
  logic       ram_rd_en;
  logic [8:0] ram_rd_addr;
  logic [7:0] ram_rd_data;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // indirect window swaps in pointer plus indirect bank bit
  function automatic logic [8:0] resolve(input logic [8:0] a,
                                         input logic [7:0] st,
                                         input logic [7:0] ptr);
    if (a[6:0] == csr_pkg::IDX_INDIRECT_WINDOW) begin
      resolve = {st[csr_pkg::BIT_INDIRECT_BANK], ptr};
    end else begin
      resolve = a;
    end
  endfunction

  // locations at and above the ram start are plain memory
  function automatic logic is_ram(input logic [8:0] a);
    is_ram = (a[6:0] >= csr_pkg::IDX_RAM_FIRST);
  endfunction

  // special register read; low 7 bits decode in every bank, except option, which reads only in odd banks
  function automatic logic [7:0] sfr_read(input logic [8:0] a,
                                          input csr_state_s s);
    sfr_read = 8'h00; // unmapped and window-through-window read 0
    case (a[6:0])
      csr_pkg::IDX_PROGRAM_COUNTER_L: sfr_read = s.pc_low;
      csr_pkg::IDX_CORE_STATUS:       sfr_read = s.status;
      csr_pkg::IDX_INDIRECT_POINTER:  sfr_read = s.pointer;
      csr_pkg::IDX_PC_HIGH_BUFFER:    sfr_read = s.pc_high_buf;
      csr_pkg::IDX_INTERRUPT_CONTROL: sfr_read = s.intr_ctrl;
      csr_pkg::IDX_TIMER_OPTION: sfr_read = a[7] ? s.option : 8'h00;
      default: sfr_read = 8'h00;
    endcase
  endfunction

  // direct address: bank bits on top of the 7-bit file address
  function automatic logic [8:0] direct_addr(input logic [6:0] a,
                                             input logic [7:0] st);
    direct_addr = {st[csr_pkg::BIT_DIRECT_BANK_HI],
                   st[csr_pkg::BIT_DIRECT_BANK_LO], a};
  endfunction

  // ---------------------------------------------------------------
  // file memory
  // ---------------------------------------------------------------
  csr_file_ram #(
    .DEPTH  (RAM_DEPTH),
    .ADDR_W (9)
  ) u_ram (
    .i_mclk    (i_mclk),
    .i_wr_en   (ram_wr_en),
    .i_wr_addr (ram_wr_addr),
    .i_wr_data (ram_wr_data),
    .i_rd_en   (ram_rd_en),
    .i_rd_addr (ram_rd_addr),
    .o_rd_data (ram_rd_data)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // one pass: pick a request, run the op or bus access, apply writes
  always_comb begin
    logic [8:0] bus_addr;   // resolved bus address
    logic [8:0] wr_addr;    // file write target
    logic [7:0] wr_data;    // file write data
    logic       wr_en;      // file write request
    logic [7:0] src;        // file operand
    logic [7:0] res;        // op result
    logic [2:0] flg;        // new flags z, nibble, carry
    logic [2:0] aff;        // flags this op changes
    logic [8:0] sum;        // full add
    logic [4:0] nib;        // low nibble add
    logic       kick;       // reset-cause set event
    next_r      = r;
    next_r.op_done = 1'b0;
    bus_addr    = resolve(i_paddr[10:2], r.status, r.pointer);
    wr_addr     = 9'h000;
    wr_data     = 8'h00;
    wr_en       = 1'b0;
    src         = 8'h00;
    res         = 8'h00;
    flg         = r.status[2:0];
    aff         = 3'h0;
    sum         = 9'h000;
    nib         = 5'h00;
    kick        = 1'b0;
    o_pready    = 1'b0;
    ram_rd_en   = 1'b0;
    ram_rd_addr = 9'h000;

    case (r.st)
      ST_IDLE: begin
        if (i_op_valid) begin
          // op wins over the bus; bus master waits in access phase
          next_r.op_code    = i_op_code;
          next_r.op_w       = i_op_w;
          next_r.op_bit     = i_op_bit;
          next_r.op_to_file = i_op_to_file;
          next_r.eff_addr   = resolve(direct_addr(i_op_addr, r.status),
                                      r.status, r.pointer);
          ram_rd_en         = 1'b1;
          ram_rd_addr       = next_r.eff_addr;
          next_r.st         = ST_OP_EXEC;
        end else if (i_psel && i_penable && i_pwrite) begin
          // write completes in this access cycle
          o_pready = 1'b1;
          wr_en    = 1'b1;
          wr_addr  = bus_addr;
          wr_data  = i_pwdata[7:0];
        end else if (i_psel && i_penable) begin
          next_r.eff_addr = bus_addr;
          ram_rd_en       = 1'b1;
          ram_rd_addr     = bus_addr;
          next_r.st       = ST_BUS_READ;
        end
      end
      ST_BUS_READ: begin
        // narrow data in low byte, upper bits zero
        next_r.prdata = {24'h000000, is_ram(r.eff_addr) ?
                         ram_rd_data : sfr_read(r.eff_addr, r)};
        next_r.st     = ST_BUS_ACK;
      end
      ST_BUS_ACK: begin
        o_pready  = 1'b1;
        next_r.st = ST_IDLE;
      end
      ST_OP_EXEC: begin
        src = is_ram(r.eff_addr) ? ram_rd_data : sfr_read(r.eff_addr, r);
        case (r.op_code)
          csr_pkg::OP_ADD: begin
            sum = {1'b0, src} + {1'b0, r.op_w};
            nib = {1'b0, src[3:0]} + {1'b0, r.op_w[3:0]};
            res = sum[7:0];
            flg = {res == 8'h00, nib[4], sum[8]};
            aff = csr_pkg::FLAG_ALL;
          end
          csr_pkg::OP_SUB: begin
            // file minus w as file plus complement plus one
            sum = {1'b0, src} + {1'b0, ~r.op_w} + 9'h001;
            nib = {1'b0, src[3:0]} + {1'b0, ~r.op_w[3:0]} + 5'h01;
            res = sum[7:0];
            flg = {res == 8'h00, nib[4], sum[8]};
            aff = csr_pkg::FLAG_ALL;
          end
          csr_pkg::OP_AND, csr_pkg::OP_OR, csr_pkg::OP_XOR: begin
            res = (r.op_code == csr_pkg::OP_AND) ? (src & r.op_w) :
                  (r.op_code == csr_pkg::OP_OR)  ? (src | r.op_w) :
                                                   (src ^ r.op_w);
            flg[2] = (res == 8'h00);
            aff    = csr_pkg::FLAG_ZERO;
          end
          csr_pkg::OP_CLEAR: begin
            res    = 8'h00;
            flg[2] = 1'b1;
            aff    = csr_pkg::FLAG_ZERO;
          end
          csr_pkg::OP_MOVE:      res = r.op_w;
          csr_pkg::OP_BIT_SET:   res = src | (8'h01 << r.op_bit);
          csr_pkg::OP_BIT_CLEAR: res = src & ~(8'h01 << r.op_bit);
          csr_pkg::OP_SWAP:      res = {src[3:0], src[7:4]};
          csr_pkg::OP_ROT_LEFT: begin
            res    = {src[6:0], r.status[csr_pkg::BIT_CARRY]};
            flg[0] = src[7];
            aff    = csr_pkg::FLAG_CARRY;
          end
          csr_pkg::OP_ROT_RIGHT: begin
            res    = {r.status[csr_pkg::BIT_CARRY], src[7:1]};
            flg[0] = src[0];
            aff    = csr_pkg::FLAG_CARRY;
          end
          csr_pkg::OP_SLEEP: begin
            next_r.status[csr_pkg::BIT_WATCHDOG_EXPIRY] = 1'b1;
            next_r.status[csr_pkg::BIT_SLEEP_ENTRY]     = 1'b0;
            kick = 1'b1;
          end
          csr_pkg::OP_WATCHDOG_KICK: begin
            next_r.status[csr_pkg::BIT_WATCHDOG_EXPIRY] = 1'b1;
            next_r.status[csr_pkg::BIT_SLEEP_ENTRY]     = 1'b1;
            kick = 1'b1;
          end
          default: res = src;
        endcase
        // flags the op changes take their results, others keep value
        next_r.status[2:0] = (r.status[2:0] & ~aff) | (flg & aff);
        // sleep and kick have no file side
        wr_en = (r.op_to_file || r.op_code == csr_pkg::OP_MOVE) && !kick;
        wr_addr          = r.eff_addr;
        wr_data          = res;
        next_r.op_result = res;
        next_r.op_done   = 1'b1;
        next_r.st        = ST_IDLE;
      end
      default: next_r.st = ST_IDLE;
    endcase

    // timeout clears expiry, but a same-cycle kick or sleep wins
    if (i_wdt_timeout && !kick) begin
      next_r.status[csr_pkg::BIT_WATCHDOG_EXPIRY] = 1'b0;
    end

    // file write into special registers; ram gets the rest
    ram_wr_en   = wr_en && is_ram(wr_addr);
    ram_wr_addr = wr_addr;
    ram_wr_data = wr_data;
    if (wr_en && !is_ram(wr_addr)) begin
      case (wr_addr[6:0])
        csr_pkg::IDX_CORE_STATUS: begin
          // bank bits written; reset-cause bits never
          next_r.status[7:5] = wr_data[7:5];
          if (aff == 3'h0) begin
            next_r.status[2:0] = wr_data[2:0];
          end // else flag results stand
        end
        csr_pkg::IDX_PROGRAM_COUNTER_L: next_r.pc_low    = wr_data;
        csr_pkg::IDX_INDIRECT_POINTER:  next_r.pointer   = wr_data;
        csr_pkg::IDX_PC_HIGH_BUFFER:
          next_r.pc_high_buf = {3'h0, wr_data[csr_pkg::PCH_BUFFER_BITS-1:0]};
        csr_pkg::IDX_INTERRUPT_CONTROL: next_r.intr_ctrl = wr_data;
        csr_pkg::IDX_TIMER_OPTION:
          if (wr_addr[7]) next_r.option = wr_data;
        default: next_r.pc_low = next_r.pc_low; // ignored
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // flags have no defined power-up value; zero keeps sims clean
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r             <= '0;
      r.st          <= ST_IDLE;
      r.status      <= csr_pkg::RST_CORE_STATUS;
      r.pointer     <= csr_pkg::RST_POINTER;
      r.pc_low      <= csr_pkg::RST_PC_LOW;
      r.pc_high_buf <= csr_pkg::RST_PC_HIGH_BUF;
      r.intr_ctrl   <= csr_pkg::RST_INTR_CONTROL;
      r.option      <= csr_pkg::RST_OPTION;
      r.op_code     <= csr_pkg::OP_MOVE;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_prdata   = r.prdata;
  assign o_pslverr  = 1'b0; // unmapped reads answer zero instead
  assign o_op_ready = (r.st == ST_IDLE);
  assign o_op_done  = r.op_done;
  assign o_op_result = r.op_result;
  assign o_core_status                 = r.status;
  assign o_indirect_pointer            = r.pointer;
  assign o_program_counter_low         = r.pc_low;
  assign o_program_counter_high_buffer = r.pc_high_buf;
  assign o_interrupt_control           = r.intr_ctrl;
  assign o_prescaler_option            = r.option;
  // prescaler owned by the watchdog leaves the timer undivided
  assign o_timer_zero_undivided =
    r.option[csr_pkg::BIT_PRESCALER_TO_WATCHDOG];

endmodule // csr_core_status

/* File: bench/csr_core_status_assertions.sv */
// checker for the core status bank, port relations only
// assumes: bound into csr_core_status, single clock domain
`timescale 1ns/1ps
module csr_core_status_chk (
  input wire logic             i_mclk,
  input wire logic             i_rst_n,
  input wire logic             i_pwrite,
  input wire logic [11:0]      i_paddr,
  input wire logic             o_pready,
  input wire logic [31:0]      o_prdata,
  input wire logic             i_op_valid,
  input wire csr_pkg::csr_op_e i_op_code,
  input wire logic [6:0]       i_op_addr,
  input wire logic             i_op_to_file,
  input wire logic             o_op_ready,
  input wire logic             o_op_done,
  input wire logic [7:0]       o_op_result,
  input wire logic             i_wdt_timeout,
  input wire logic [7:0]       o_core_status,
  input wire logic [7:0]       o_prescaler_option,
  input wire logic             o_timer_zero_undivided
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic tk; // op taken this edge
  assign tk = i_op_valid && o_op_ready;
  // op answer two edges after taking
  property p_done; tk |=> !o_op_ready ##1 o_op_done; endproperty
  a_done: assert property (p_done) else $error("op done late");
  // cause bits move only on their own events
  property p_hold; !$past(i_wdt_timeout) && !o_op_done
    |-> $stable(o_core_status[4:3]); endproperty
  a_hold: assert property (p_hold) else $error("cause moved");
  property p_tmo; i_wdt_timeout && o_op_ready && !i_op_valid
    |=> !o_core_status[4]; endproperty
  a_tmo: assert property (p_tmo) else $error("expiry kept");
  property p_slp; tk && i_op_code inside {csr_pkg::OP_SLEEP,
    csr_pkg::OP_WATCHDOG_KICK} |=> ##1 o_core_status[4] &&
    o_core_status[3] == ($past(i_op_code, 2) == csr_pkg::OP_WATCHDOG_KICK);
  endproperty
  a_slp: assert property (p_slp) else $error("cause bits wrong");
  property p_clr; tk && i_op_code == csr_pkg::OP_CLEAR && i_op_to_file &&
    i_op_addr == csr_pkg::IDX_CORE_STATUS |=> ##1 o_core_status[7:5] == 3'h0
    && o_core_status[2] && o_core_status[1:0] == $past(o_core_status[1:0], 2);
  endproperty
  a_clr: assert property (p_clr) else $error("clear of status");
  // zero flag follows every add, subtract, and, or, xor result
  property p_zero; o_op_done && $past(tk, 2) && $past(i_op_code, 2) <=
    csr_pkg::OP_XOR |-> o_core_status[2] == (o_op_result == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag");
  property p_keep; tk && i_op_code inside {[csr_pkg::OP_MOVE:csr_pkg::OP_SWAP]}
    && i_op_addr >= csr_pkg::IDX_RAM_FIRST
    |=> ##1 o_core_status[2:0] == $past(o_core_status[2:0], 2); endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
  property p_unimp; o_pready && !i_pwrite && i_paddr[8:2] == 7'h0d
    |-> o_prdata == 32'h0; endproperty
  a_unimp: assert property (p_unimp) else $error("hole read");
  property p_undiv; $changed(o_prescaler_option[3])
    |-> ##[0:1] o_timer_zero_undivided == o_prescaler_option[3]; endproperty
  a_undiv: assert property (p_undiv) else $error("timer rate");
  c_sleep: cover property (tk && i_op_code == csr_pkg::OP_SLEEP);
  c_tmo: cover property (i_wdt_timeout);
  c_read: cover property (o_pready && !i_pwrite);
endmodule // csr_core_status_chk
bind csr_core_status csr_core_status_chk i_chk (.i_mclk, .i_rst_n,
  .i_pwrite, .i_paddr, .o_pready, .o_prdata, .i_op_valid, .i_op_code,
  .i_op_addr, .i_op_to_file, .o_op_ready, .o_op_done, .o_op_result,
  .i_wdt_timeout, .o_core_status, .o_prescaler_option,
  .o_timer_zero_undivided);

/* File: bench/tb_csr_core_status.sv */
// self-checking bench for the core status bank
// assumes: apb master and core op sequencer played by the bench
`timescale 1ns/1ps
module tb_csr_core_status;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic i_pwrite = 1'b0, i_op_valid = 1'b0, i_op_to_file = 1'b0;
  logic i_wdt_timeout = 1'b0, o_pready, o_pslverr, o_op_ready, o_op_done;
  logic o_timer_zero_undivided;
  logic [11:0] i_paddr = 12'h0;
  logic [31:0] i_pwdata = 32'h0, o_prdata;
  logic [6:0] i_op_addr = 7'h0;
  logic [7:0] i_op_w = 8'h0, o_op_result, o_core_status, o_indirect_pointer;
  logic [7:0] o_program_counter_low, o_program_counter_high_buffer;
  logic [7:0] o_interrupt_control, o_prescaler_option;
  logic [2:0] i_op_bit = 3'h0;
  csr_pkg::csr_op_e i_op_code = csr_pkg::OP_ADD;
  int fail_count = 0, compares = 0, cyc = 0;
  // alu table: file, w, result, flags after
  logic [31:0] tv [8] = '{32'h8f710007, 32'h0001ff00, 32'h35122303,
    32'hf00f0007, 32'h40014103, 32'h55550007, 32'h02008106, 32'h80000007};
  csr_pkg::csr_op_e tc [8] = '{csr_pkg::OP_ADD, csr_pkg::OP_SUB,
    csr_pkg::OP_SUB, csr_pkg::OP_AND, csr_pkg::OP_OR, csr_pkg::OP_XOR,
    csr_pkg::OP_ROT_RIGHT, csr_pkg::OP_ROT_LEFT};
  csr_core_status i_dut (.i_mclk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_op_valid,
    .i_op_code, .i_op_addr, .i_op_w, .i_op_bit, .i_op_to_file, .o_op_ready,
    .o_op_done, .o_op_result, .i_wdt_timeout, .o_core_status,
    .o_indirect_pointer, .o_program_counter_low,
    .o_program_counter_high_buffer, .o_interrupt_control,
    .o_prescaler_option, .o_timer_zero_undivided);
  always #25 i_mclk = ~i_mclk; // 20 MHz
  // hang guard, run needs well under 3000 cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  task automatic chk(logic [7:0] g, logic [7:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer; waits for pready at a rising edge
  task automatic bus(logic w, logic [8:0] a, logic [7:0] d,
                     output logic [7:0] q);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= {1'b0, a, 2'b00};
    i_pwdata <= {24'h0, d};
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    q = o_prdata[7:0];
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(negedge i_mclk);
  endtask
  task automatic wr(logic [8:0] a, logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(logic [8:0] a, logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // one core op, result always to the file
  task automatic op(csr_pkg::csr_op_e c, logic [6:0] a, logic [7:0] w,
                    logic [2:0] b);
    @(posedge i_mclk);
    i_op_valid <= 1'b1;
    i_op_code <= c;
    i_op_addr <= a;
    i_op_w <= w;
    i_op_bit <= b;
    i_op_to_file <= 1'b1;
    do @(posedge i_mclk); while (o_op_ready !== 1'b1);
    i_op_valid <= 1'b0;
    do @(negedge i_mclk); while (o_op_done !== 1'b1);
  endtask
  task automatic t_protect;
    chk(o_core_status, 8'h18);
    wr(9'h083, 8'h00);
    rdc(9'h103, 8'h18);
    wr(9'h183, 8'h07);
    rdc(9'h003, 8'h1f);
  endtask
  task automatic t_cause;
    op(csr_pkg::OP_SLEEP, 7'h0, 8'h0, 3'h0);
    chk(o_core_status, 8'h17);
    @(posedge i_mclk);
    i_wdt_timeout <= 1'b1;
    @(posedge i_mclk);
    i_wdt_timeout <= 1'b0;
    @(negedge i_mclk);
    chk(o_core_status, 8'h07);
    op(csr_pkg::OP_WATCHDOG_KICK, 7'h0, 8'h0, 3'h0);
    chk(o_core_status, 8'h1f);
  endtask
  task automatic t_alu;
    for (int i = 0; i < 8; i++) begin
      wr(9'h020, tv[i][31:24]);
      op(tc[i], 7'h20, tv[i][23:16], 3'h0);
      chk(o_op_result, tv[i][15:8]);
      chk({5'h0, o_core_status[2:0]}, tv[i][7:0]);
      rdc(9'h020, tv[i][15:8]);
    end
  endtask
  // status as destination of flag and non-flag ops
  task automatic t_dest;
    op(csr_pkg::OP_ADD, 7'h03, 8'h01, 3'h0);
    chk(o_core_status, 8'h3a);
    wr(9'h003, 8'he9);
    op(csr_pkg::OP_CLEAR, 7'h03, 8'h00, 3'h0);
    chk(o_core_status, 8'h1d);
    op(csr_pkg::OP_MOVE, 7'h03, 8'ha0, 3'h0);
    op(csr_pkg::OP_BIT_SET, 7'h03, 8'h00, 3'h0);
    op(csr_pkg::OP_BIT_CLEAR, 7'h03, 8'h00, 3'h7);
    chk(o_core_status, 8'h39);
    op(csr_pkg::OP_SWAP, 7'h03, 8'h00, 3'h0);
    chk(o_core_status, 8'h9b);
  endtask
  task automatic t_bank;
    for (int r = 0; r < 4; r++) wr({r[1:0], 7'h25}, 8'h40 + 8'(r));
    for (int r = 0; r < 4; r++) begin
      wr(9'h003, {1'b0, r[1:0], 5'h00});
      op(csr_pkg::OP_AND, 7'h25, 8'hff, 3'h0);
      chk(o_op_result, 8'h40 + 8'(r));
    end
    op(csr_pkg::OP_SWAP, 7'h25, 8'h00, 3'h0);
    chk(o_op_result, 8'h34);
    chk(o_core_status, 8'h78);
    wr(9'h030, 8'h11);
    wr(9'h130, 8'h22);
    wr(9'h004, 8'h30);
    chk(o_indirect_pointer, 8'h30);
    wr(9'h003, 8'h80);
    op(csr_pkg::OP_AND, 7'h00, 8'hff, 3'h0);
    chk(o_op_result, 8'h22);
    wr(9'h003, 8'h00);
    rdc(9'h000, 8'h11);
    wr(9'h000, 8'h33);
    rdc(9'h030, 8'h33);
  endtask
  task automatic t_unimpl;
    wr(9'h00d, 8'h55);
    rdc(9'h00d, 8'h00);
    wr(9'h00a, 8'hff);
    rdc(9'h08a, 8'h1f);
    chk(o_program_counter_high_buffer, 8'h1f);
    wr(9'h102, 8'ha5);
    chk(o_program_counter_low, 8'ha5);
    wr(9'h18b, 8'h5a);
    rdc(9'h00b, 8'h5a);
    chk(o_interrupt_control, 8'h5a);
    rdc(9'h101, 8'h00);
    wr(9'h181, 8'h00);
    rdc(9'h081, 8'h00);
    chk({7'h0, o_timer_zero_undivided}, 8'h00);
    wr(9'h081, 8'h08);
    chk({7'h0, o_timer_zero_undivided}, 8'h01);
    chk(o_prescaler_option, 8'h08);
    chk({7'h0, o_pslverr}, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rdc(9'h081, 8'hff);
    t_protect;
    t_cause;
    t_alu;
    t_dest;
    t_bank;
    t_unimpl;
    tally_and_finish;
  end
endmodule // tb_csr_core_status
